// ===== hw/dtf_port.sv
// Serial debug port datapath: writeback operand latch, status save latch,
// control latch and change-of-flow trace ring behind one serial link.
// Assumes the link pins are asynchronous and the core signals share clk.
//
// Overview of operation
// [R01] Forced instruction result in debug mode lands in the writeback latch.
// [R02] Writeback latch contents can be shifted out to the controller.
// [R03] With feed select set, writeback latch replaces move source operand.
// [R04] Substitution applies to the first instruction after a control update.
// [R05] A 32-bit status save latch reads and writes the core status.
// [R06] Controller saves status before disturbing it and restores it on exit.
// [R07] Trace ring keeps the last eight change-of-flow prefetch targets.
// [R08] Eight 32-bit circular entries, 3-bit pointer, one shared address.
// [R09] Each trace read returns the pointed entry, then steps the pointer.
// [R10] In debug mode only reads move the pointer; entries stay put.
// [R11] On debug entry the pointer names the oldest address.
// [R12] Controller always reads the trace ring eight times in a row.
// [R13] Controller leaves the factory test registers alone in normal use.
// [R14] Device acknowledges debug entry; controller waits for it first.
// [R15] Transaction is an 8-bit command, then 0, 16 or 32 data bits.
// [R16] Commands and data shift least significant bit first both ways.
// [R17] Device flags execution done; controller waits before next access.
// [R18] Read, write and no-data command classes are supported.
// [R19] Outside debug mode each capture overwrites the oldest entry and steps.
`timescale 1ns/1ps
`default_nettype none
module dtf_port #(
    parameter int unsigned TRACE_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dbgClk,
    input wire logic dbgIn,
    input wire logic dbgSel,
    output logic dbgOut,
    output logic dbgOutEn,
    output logic dbgAck,
    output logic dbgDone,
    input wire logic cpuDebugMode,
    input wire dtf_pkg::dtf_word_t cpuCof,
    input wire dtf_pkg::dtf_word_t cpuResult,
    input wire logic [dtf_pkg::WORD_W-1:0] cpuStatus,
    output logic execReq,
    output logic operandFeedEn,
    output logic [dtf_pkg::WORD_W-1:0] operandFeedValue,
    output logic statusWrite,
    output logic [dtf_pkg::WORD_W-1:0] statusWriteValue,
    output logic [dtf_pkg::CTL_W-1:0] controlState,
    output logic [dtf_pkg::TRACE_PTR_W-1:0] tracePtr
);
    import dtf_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD = 4'b0010,
        ST_DATA = 4'b0100,
        ST_HOLD = 4'b1000
    } dtf_state_t;

    dtf_state_t state;
    logic [2:0] clkSync;
    logic [1:0] inSync;
    logic [1:0] selSync;
    logic linkRise;
    logic linkFall;
    logic debugModeQ;
    logic [CMD_W-1:0] cmdShift;
    logic [CMD_W-1:0] next_cmdShift;
    dtf_cmd_t cmd;
    dtf_cmd_t newCmd;
    logic [CNT_W-1:0] bitCnt;
    logic [CNT_W-1:0] dataLen;
    logic [WORD_W-1:0] shiftReg;
    logic [WORD_W-1:0] next_shiftReg;
    logic [WORD_W-1:0] writeback;
    logic [WORD_W-1:0] statusLatch;
    logic [WORD_W-1:0] traceData;
    logic feedArmed;
    logic traceAdvance;
    logic cmdComplete;
    logic dataComplete;
    logic ctlUpdate;

    // Bit count of the data phase for a register select
    function automatic logic [CNT_W-1:0] lenOf(input logic [3:0] sel);
        if (sel == SEL_WRITEBACK) begin
            lenOf = LEN_WORD;
        end else if (sel == SEL_STATUS) begin
            lenOf = LEN_WORD;
        end else if (sel == SEL_TRACE) begin
            lenOf = LEN_WORD;
        end else if (sel == SEL_CONTROL) begin
            lenOf = LEN_CTL;
        end else begin
            lenOf = LEN_NONE;
        end
    endfunction

    // Pins cross from the link domain through two flops, the link clock through three
    always_ff @(posedge clk) begin
        if (rst) begin
            clkSync <= 3'h0;
            inSync <= 2'h0;
            selSync <= 2'h0;
        end else begin
            clkSync <= {clkSync[1:0], dbgClk};
            inSync <= {inSync[0], dbgIn};
            selSync <= {selSync[0], dbgSel};
        end
    end

    // Edges judged on the second and third stage only
    assign linkRise = clkSync[1] & ~clkSync[2];
    assign linkFall = ~clkSync[1] & clkSync[2];

    // Serial bits enter at the top so the first bit ends lowest
    assign next_cmdShift = {inSync[1], cmdShift[CMD_W-1:1]}; // [R16]
    assign next_shiftReg = {inSync[1], shiftReg[WORD_W-1:1]}; // [R16]
    assign newCmd = dtf_cmd_t'(next_cmdShift);
    assign cmdComplete = (state == ST_CMD) && linkRise
        && (bitCnt == CMD_LAST_BIT); // [R15]
    assign dataComplete = (state == ST_DATA) && linkRise
        && (bitCnt == CNT_W'(dataLen - 1'b1)); // [R15]
    assign traceAdvance = cmdComplete && debugModeQ && newCmd.rd
        && (newCmd.sel == SEL_TRACE); // [R09]
    assign ctlUpdate = dataComplete && !cmd.rd
        && (cmd.sel == SEL_CONTROL);

    // Frame sequencer; a dropped select aborts whatever is running
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (!selSync[1]) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_CMD;
                end
                ST_CMD: begin
                    if (cmdComplete) begin
                        // Commands before the acknowledge are swallowed
                        if (!debugModeQ) begin
                            state <= ST_HOLD; // [R14]
                        end else if (lenOf(newCmd.sel) == LEN_NONE) begin
                            state <= ST_HOLD; // [R18]
                        end else begin
                            state <= ST_DATA; // [R15] [R18]
                        end
                    end
                end
                ST_DATA: begin
                    if (dataComplete) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state <= ST_HOLD;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Bit counter and latched command for the current frame
    always_ff @(posedge clk) begin
        if (rst) begin
            bitCnt <= CNT_RESET;
            cmdShift <= CMD_RESET;
            cmd <= dtf_cmd_t'(CMD_RESET);
            dataLen <= CNT_RESET;
        end else if (state == ST_IDLE) begin
            bitCnt <= CNT_RESET;
        end else if (cmdComplete) begin
            bitCnt <= CNT_RESET;
            cmdShift <= next_cmdShift;
            cmd <= newCmd; // [R15]
            dataLen <= lenOf(newCmd.sel);
        end else if (linkRise && (state == ST_CMD || state == ST_DATA)) begin
            bitCnt <= CNT_W'(bitCnt + 1'b1);
            if (state == ST_CMD) begin
                cmdShift <= next_cmdShift;
            end
        end
    end

    // Data shifter: loaded for reads, fills from the top for writes
    always_ff @(posedge clk) begin
        if (rst) begin
            shiftReg <= WORD_RESET;
        end else if (cmdComplete && newCmd.rd) begin
            if (newCmd.sel == SEL_WRITEBACK) begin
                shiftReg <= writeback; // [R02]
            end else if (newCmd.sel == SEL_STATUS) begin
                shiftReg <= statusLatch; // [R05]
            end else if (newCmd.sel == SEL_TRACE) begin
                shiftReg <= traceData; // [R09]
            end else begin
                shiftReg <= {{(WORD_W-CTL_W){1'b0}}, controlState};
            end
        end else if (linkRise && state == ST_DATA) begin
            shiftReg <= next_shiftReg; // [R16]
        end
    end

    // Output bit changes on the link's falling edge for a stable sample
    always_ff @(posedge clk) begin
        if (rst) begin
            dbgOut <= 1'b0;
            dbgOutEn <= 1'b0;
        end else begin
            dbgOutEn <= (state == ST_DATA) && cmd.rd; // [R18]
            if (linkFall && state == ST_DATA && cmd.rd) begin
                dbgOut <= shiftReg[0]; // [R02] [R16]
            end
        end
    end

    // Writeback latch: serial load, or result of a forced instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            writeback <= WORD_RESET;
        end else if (cpuResult.valid && debugModeQ) begin
            writeback <= cpuResult.data; // [R01]
        end else if (dataComplete && !cmd.rd
                     && cmd.sel == SEL_WRITEBACK) begin
            writeback <= next_shiftReg;
        end
    end

    // Status save latch: caught on debug entry, rewritten by controller
    always_ff @(posedge clk) begin
        if (rst) begin
            statusLatch <= WORD_RESET;
            statusWrite <= 1'b0;
        end else begin
            statusWrite <= 1'b0;
            if (cpuDebugMode && !debugModeQ) begin
                statusLatch <= cpuStatus; // [R05]
            end else if (dataComplete && !cmd.rd
                         && cmd.sel == SEL_STATUS) begin
                statusLatch <= next_shiftReg; // [R05]
                statusWrite <= 1'b1;
            end
        end
    end

    // Written status word mirrors the latch, valid with the pulse
    assign statusWriteValue = statusLatch; // [R05]

    // Control latch; the 16-bit value arrives in the upper half
    always_ff @(posedge clk) begin
        if (rst) begin
            controlState <= CTL_RESET;
        end else if (ctlUpdate) begin
            controlState <= next_shiftReg[WORD_W-1:WORD_W-CTL_W];
        end
    end

    // Feed lasts for one executed instruction only, so a later move
    // does not silently repeat the stale operand
    always_ff @(posedge clk) begin
        if (rst) begin
            feedArmed <= 1'b0;
        end else if (ctlUpdate) begin
            feedArmed <= 1'b1; // [R04]
        end else if (cpuResult.valid) begin
            feedArmed <= 1'b0; // [R04]
        end
    end

    assign operandFeedEn = feedArmed
        && controlState[FEED_SELECT_BIT]; // [R03] [R04]
    assign operandFeedValue = writeback; // [R03]

    // Execution request after the command, or after its data if any
    always_ff @(posedge clk) begin
        if (rst) begin
            execReq <= 1'b0;
        end else begin
            execReq <= (cmdComplete && debugModeQ && newCmd.exec
                        && lenOf(newCmd.sel) == LEN_NONE)
                    || (dataComplete && cmd.exec); // [R18]
        end
    end

    // Done flag: cleared by a request, set by completion; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            dbgDone <= 1'b1;
        end else if (cpuResult.valid) begin
            dbgDone <= 1'b1; // [R17]
        end else if (execReq) begin
            dbgDone <= 1'b0; // [R17]
        end
    end

    // Debug-mode acknowledge seen by the controller
    always_ff @(posedge clk) begin
        if (rst) begin
            debugModeQ <= 1'b0;
            dbgAck <= 1'b0;
        end else begin
            debugModeQ <= cpuDebugMode;
            dbgAck <= cpuDebugMode; // [R14]
        end
    end

    // Trace ring; recording stops in debug mode so reads stay coherent
    dtf_trace_ring #(
        .DEPTH(TRACE_DEPTH),
        .PTR_W(TRACE_PTR_W),
        .ADDR_W(WORD_W)
    ) u_ring (
        .clk(clk),
        .rst(rst),
        .recordEn(cpuCof.valid && !cpuDebugMode), // [R10] [R19]
        .recordAddr(cpuCof.data),
        .readAdvance(traceAdvance), // [R09] [R12]
        .readData(traceData),
        .ptr(tracePtr)
    );

endmodule
`default_nettype wire

// ===== hw/dtf_pkg.sv
// Shared constants and carrier types for the debug trace and latch port.
// Assumes a single 200 MHz system clock; no header guard needed.
package dtf_pkg;

    // Register widths
    localparam int unsigned WORD_W = 32;
    localparam int unsigned CTL_W = 16;
    localparam int unsigned CMD_W = 8;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned TRACE_PTR_W = 3;

    // Register select codes carried in the command byte
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_WRITEBACK = 4'h1;
    localparam logic [3:0] SEL_STATUS = 4'h2;
    localparam logic [3:0] SEL_TRACE = 4'h3;
    localparam logic [3:0] SEL_CONTROL = 4'h4;

    // Data lengths in bits per selected register, and the last command bit index
    localparam logic [6:0] LEN_NONE = 7'h00;
    localparam logic [6:0] LEN_WORD = 7'h20;
    localparam logic [6:0] LEN_CTL = 7'h10;
    localparam logic [6:0] CMD_LAST_BIT = 7'h07;

    // Field position of the operand feed select bit in the control latch
    localparam int unsigned FEED_SELECT_BIT = 0;

    // Values after reset
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [6:0] CNT_RESET = 7'h00;

    // Command byte, shifted in least significant bit first
    typedef struct packed {
        logic [1:0] spare;
        logic exec;
        logic rd;
        logic [3:0] sel;
    } dtf_cmd_t;

    // Qualified 32-bit word from the core
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } dtf_word_t;

endpackage

// ===== hw/dtf_trace_ring.sv
// Circular buffer of change-of-flow prefetch addresses with one read port.
// Assumes record and advance come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dtf_trace_ring #(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned PTR_W = dtf_pkg::TRACE_PTR_W,
    parameter int unsigned ADDR_W = dtf_pkg::WORD_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic recordEn,
    input wire logic [ADDR_W-1:0] recordAddr,
    input wire logic readAdvance,
    output logic [ADDR_W-1:0] readData,
    output logic [PTR_W-1:0] ptr
);
    import dtf_pkg::*;

    logic [ADDR_W-1:0] entry [DEPTH];

    // Entry storage; writes land on the oldest slot
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= '0;
            end
        end else if (recordEn) begin
            entry[ptr] <= recordAddr; // [R07] [R19]
        end
    end

    // Pointer names the oldest entry outside read sequences; wraps modulo depth
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= '0;
        end else if (recordEn || readAdvance) begin
            ptr <= PTR_W'((ptr + 1'b1) % DEPTH); // [R08] [R09] [R11] [R19]
        end
    end

    // Shared read address shows the slot under the pointer
    assign readData = entry[ptr]; // [R08]

endmodule
`default_nettype wire

// ===== hw/dtf_port_fix.sv
// Reserved for later port extensions; holds no code.

// ===== testbench/dtf_port_chk.sv
// Checker for the debug port: timing relations seen at the top ports.
// Assumes one clock domain, clk, with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module dtf_port_chk #(
    parameter int unsigned TRACE_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dbgSel,
    input wire logic dbgAck,
    input wire logic dbgDone,
    input wire logic cpuDebugMode,
    input wire dtf_pkg::dtf_word_t cpuCof,
    input wire dtf_pkg::dtf_word_t cpuResult,
    input wire logic execReq,
    input wire logic operandFeedEn,
    input wire logic [dtf_pkg::WORD_W-1:0] operandFeedValue,
    input wire logic statusWrite,
    input wire logic [dtf_pkg::CTL_W-1:0] controlState,
    input wire logic [dtf_pkg::TRACE_PTR_W-1:0] tracePtr
);
    import dtf_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // Handshake and command authority
    ack_follow_a: assert property (cpuDebugMode |=> dbgAck)
        else $error("debug entry not acknowledged");
    cmd_auth_a: assert property ((execReq || statusWrite) |-> dbgAck)
        else $error("command acted on without acknowledge");
    // Pointer moves by one only; jumps in debug mode leave it alone
    cof_step_a: assert property (cpuCof.valid && !cpuDebugMode |=>
        tracePtr == $past(tracePtr) + 3'h1)
        else $error("capture did not step pointer");
    ptr_step_a: assert property (
        cpuDebugMode && $changed(tracePtr) |->
        tracePtr == $past(tracePtr) + 3'h1)
        else $error("pointer jumped in debug mode");
    cof_hold_a: assert property (
        cpuDebugMode && cpuCof.valid && !dbgSel |=> $stable(tracePtr))
        else $error("ring changed by debug-mode jump");
    // Completion flag around a forced execution
    done_drop_a: assert property (execReq && !cpuResult.valid |=>
        !dbgDone)
        else $error("done stayed high after execute");
    done_set_a: assert property (cpuResult.valid |=> dbgDone)
        else $error("done not set by result");
    // Result capture and operand feed
    wb_load_a: assert property (cpuResult.valid && cpuDebugMode |=>
        operandFeedValue == $past(cpuResult.data))
        else $error("result not latched");
    // Feed may only arm inside a framed control write with the bit set
    feed_gate_a: assert property ($rose(operandFeedEn) |->
        dbgSel && controlState[FEED_SELECT_BIT])
        else $error("feed armed outside a control write");
    feed_clear_a: assert property (cpuResult.valid |=> !operandFeedEn)
        else $error("feed outlived first instruction");

    cover property (execReq ##[1:20] cpuResult.valid);
    cover property (operandFeedEn && execReq);
    cover property (cpuDebugMode && $changed(tracePtr));
endmodule

bind dtf_port dtf_port_chk #(.TRACE_DEPTH(TRACE_DEPTH)) i_chk (
    .clk, .rst, .dbgSel, .dbgAck, .dbgDone, .cpuDebugMode, .cpuCof,
    .cpuResult, .execReq, .operandFeedEn, .operandFeedValue,
    .statusWrite, .controlState, .tracePtr
);
`default_nettype wire

// ===== testbench/dtf_link_model.sv
// Serial debug controller model: frames commands and data on the link.
// Assumes the port samples the link with clk; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module dtf_link_model (
    input wire logic clk,
    input wire logic dbgAck,
    input wire logic dbgDone,
    input wire logic dbgOut,
    input wire logic dbgOutEn,
    output logic dbgClk,
    output logic dbgIn,
    output logic dbgSel,
    output logic oeOk
);
    initial begin
        dbgClk = 1'b0;
        dbgIn = 1'b1;
        dbgSel = 1'b0;
        oeOk = 1'b1;
    end

    // One bit: set on the fall, sample on the rise, 8 clk per half
    task automatic bit_x(input logic b, input logic rd, output logic q);
        @(negedge clk);
        dbgClk = 1'b0;
        dbgIn = b;
        repeat (8) @(negedge clk);
        dbgClk = 1'b1;
        q = dbgOut;
        if (rd && dbgOutEn !== 1'b1)
            oeOk = 1'b0;
        repeat (7) @(negedge clk);
    endtask

    // Command then n data bits, both LSB first
    // Only selects 0..4 are sent, so factory test registers stay idle
    task automatic frame(input logic [7:0] cmd, input logic [31:0] wd,
                         input int n, output logic [31:0] rd);
        logic q;
        int i;
        for (i = 0; i < 200 && dbgAck !== 1'b1; i++)
            @(negedge clk);
        rd = 32'h0000_0000;
        dbgSel = 1'b1;
        for (i = 0; i < 8; i++)
            bit_x(cmd[i], 1'b0, q);
        for (i = 0; i < n; i++) begin
            bit_x(wd[i], cmd[4], q);
            rd[i] = q;
        end
        // Released data line shows the inverse, not the last bit
        @(negedge clk);
        dbgClk = 1'b0;
        dbgIn = ~dbgIn;
        repeat (8) @(negedge clk);
        dbgSel = 1'b0;
        repeat (6) @(negedge clk);
        for (i = 0; i < 200 && cmd[5] && dbgDone !== 1'b1; i++)
            @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the debug port with a core stub and link model.
// Assumes dtf_pkg, dtf_port, the checker and the link model are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dtf_pkg::*;
    localparam logic [31:0] COF_BASE = 32'h0000_1000;
    localparam logic [31:0] ST_A = 32'h0000_00c5;
    localparam logic [31:0] ST_B = 32'h8000_0001;
    localparam logic [31:0] REG_VAL = 32'h5a5a_0f0f;
    localparam logic [31:0] W_VAL = 32'h1234_5678;
    logic clk, rst, dbgClk, dbgIn, dbgSel, dbgOut, dbgOutEn, dbgAck;
    logic dbgDone, cpuDebugMode, execReq, operandFeedEn, statusWrite;
    logic oeOk, feedSeen;
    dtf_word_t cpuCof, cpuResult;
    logic [31:0] cpuStatus, operandFeedValue, rd, feedVal;
    logic [31:0] statusWriteValue, lastStatusWr;
    logic [15:0] controlState;
    logic [2:0] tracePtr;
    int err_total, checks, i, nStatusWr;

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    dtf_port #(.TRACE_DEPTH(8)) i_dut (
        .clk(clk), .rst(rst), .dbgClk(dbgClk), .dbgIn(dbgIn),
        .dbgSel(dbgSel), .dbgOut(dbgOut), .dbgOutEn(dbgOutEn),
        .dbgAck(dbgAck), .dbgDone(dbgDone), .cpuDebugMode(cpuDebugMode),
        .cpuCof(cpuCof), .cpuResult(cpuResult), .cpuStatus(cpuStatus),
        .execReq(execReq), .operandFeedEn(operandFeedEn),
        .operandFeedValue(operandFeedValue), .statusWrite(statusWrite),
        .statusWriteValue(statusWriteValue), .controlState(controlState),
        .tracePtr(tracePtr)
    );

    dtf_link_model i_ctl (
        .clk(clk), .dbgAck(dbgAck), .dbgDone(dbgDone), .dbgOut(dbgOut),
        .dbgOutEn(dbgOutEn), .dbgClk(dbgClk), .dbgIn(dbgIn),
        .dbgSel(dbgSel), .oeOk(oeOk)
    );

    // Core stub: a forced move ends 3 clk later; with feed on it moves
    // the fed operand, else it returns a fixed register value
    initial begin
        cpuResult = '0;
        forever begin
            @(negedge clk iff execReq === 1'b1);
            feedSeen = operandFeedEn;
            feedVal = operandFeedValue;
            repeat (3) @(negedge clk);
            cpuResult = {1'b1, (feedSeen === 1'b1) ? feedVal : REG_VAL};
            @(negedge clk);
            cpuResult.valid = 1'b0;
        end
    end

    // Status writes are pulses; sampled off the edge that launches them
    always @(negedge clk) begin
        if (statusWrite === 1'b1) begin
            nStatusWr++;
            lastStatusWr = statusWriteValue;
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
            $display("ERROR %s expected %h seen %h", what, exp, got);
        if (got !== exp)
            err_total++;
    endtask

    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: about twenty frames of ~700 clk fit well inside this
    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        cpuDebugMode = 1'b0;
        cpuCof = '0;
        cpuStatus = ST_A;
        err_total = 0;
        checks = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        cmp_bit("done", 1'b1, dbgDone);
        cmp("ptr", 32'h0000_0000, 32'(tracePtr));
        // Ten jumps: the first two are overwritten by the ring wrap
        for (i = 0; i < 10; i++) begin
            cpuCof = {1'b1, COF_BASE + 32'(i)};
            @(negedge clk);
            cpuCof.valid = 1'b0;
            @(negedge clk);
        end
        cmp("ptr", 32'h0000_0002, 32'(tracePtr));
        // Control write before acknowledge must be ignored
        i_ctl.frame(8'h04, 32'h0000_0001, 16, rd);
        cmp("ctl", 32'h0000_0000, 32'(controlState));
        cpuDebugMode = 1'b1;
        repeat (2) @(negedge clk);
        cmp_bit("ack", 1'b1, dbgAck);
        cpuCof = {1'b1, 32'hdead_0000};
        @(negedge clk);
        cpuCof.valid = 1'b0;
        // Eight reads walk oldest to newest and restore the pointer
        for (i = 0; i < 8; i++) begin
            i_ctl.frame(8'h13, 32'h0000_0000, 32, rd);
            cmp("trace", COF_BASE + 32'(i + 2), rd);
            cmp("ptr", 32'((i + 3) % 8), 32'(tracePtr));
        end
        cmp_bit("oe", 1'b1, oeOk);
        // Save status, overwrite it, read it back
        i_ctl.frame(8'h12, 32'h0000_0000, 32, rd);
        cmp("status", ST_A, rd);
        i_ctl.frame(8'h02, ST_B, 32, rd);
        cmp("statuswr", 32'h0000_0001, 32'(nStatusWr));
        cmp("statuswrval", ST_B, lastStatusWr);
        i_ctl.frame(8'h12, 32'h0000_0000, 32, rd);
        cmp("status", ST_B, rd);
        // Forced move with no data, result read back over the link
        i_ctl.frame(8'h20, 32'h0000_0000, 0, rd);
        cmp_bit("feed", 1'b0, feedSeen);
        i_ctl.frame(8'h11, 32'h0000_0000, 32, rd);
        cmp("wb", REG_VAL, rd);
        // Feed select on: next move writes the latch value through
        i_ctl.frame(8'h04, 32'h0000_0001, 16, rd);
        cmp("ctl", 32'h0000_0001, 32'(controlState));
        cmp_bit("feeden", 1'b1, operandFeedEn);
        // Control read back; a read must not disarm the feed
        i_ctl.frame(8'h14, 32'h0000_0000, 16, rd);
        cmp("ctlrd", 32'h0000_0001, rd);
        i_ctl.frame(8'h21, W_VAL, 32, rd);
        cmp_bit("done", 1'b1, dbgDone);
        cmp_bit("feed", 1'b1, feedSeen);
        cmp("feedval", W_VAL, feedVal);
        cmp_bit("feeden", 1'b0, operandFeedEn);
        i_ctl.frame(8'h11, 32'h0000_0000, 32, rd);
        cmp("wb", W_VAL, rd);
        // Restore status and control before leaving debug mode
        i_ctl.frame(8'h02, ST_A, 32, rd);
        cmp("statuswrval", ST_A, lastStatusWr);
        i_ctl.frame(8'h04, 32'h0000_0000, 16, rd);
        cpuDebugMode = 1'b0;
        repeat (2) @(negedge clk);
        cmp_bit("ack", 1'b0, dbgAck);
        finish_test();
    end
endmodule
`default_nettype wire
